// ### hw/fpp_map.svh
// Register offsets, codes and timing counts of the flash programming port
`ifndef FPP_MAP_SVH
`define FPP_MAP_SVH
// Link register addresses
`define FPP_ADDR_CTL      8'h02
`define FPP_ADDR_DAT      8'hb4
// Reset values
`define FPP_ADDR_RST      8'h00
`define FPP_CTL_RST       8'h00
`define FPP_DAT_RST       8'h00
// Unlock codes, in the order they must arrive
`define FPP_UNLOCK_FIRST  8'h02
`define FPP_UNLOCK_SECOND 8'h01
// Flash command codes
`define FPP_CMD_BLK_RD    8'h06
`define FPP_CMD_BLK_WR    8'h07
`define FPP_CMD_PG_ERASE  8'h08
`define FPP_CMD_DEV_ERASE 8'h03
// Frame layout: two instruction bits, then eight data bits, both LSB first
`define FPP_INSTR_BITS    4'd2
`define FPP_LAST_BIT      4'd9
// Clock-high time that ends a frame, least time so rounded up
`define FPP_IDLE_NS       2000
`define FPP_CLK_MHZ       25
`define FPP_IDLE_CYC      ((`FPP_IDLE_NS * `FPP_CLK_MHZ + 999) / 1000)
`endif

// ### hw/fpp_pkg.sv
// Types shared by the flash programming port
package fpp_pkg;
	// Link instructions, in wire encoding order
	typedef enum logic [1:0] {
		FPP_I_ADDR_WR,
		FPP_I_DATA_WR,
		FPP_I_DATA_RD,
		FPP_I_ADDR_RD
	} fpp_instr_t;
	// Unlock progress
	typedef enum logic [1:0] {
		FPP_LOCKED,
		FPP_HALF,
		FPP_OPEN
	} fpp_lock_t;
endpackage

// ### hw/fpp_port.sv
// Flash programming register path behind the two-wire debug link
`timescale 1ns/1ps
`default_nettype none
`include "fpp_map.svh"
module fpp_port #(
	parameter int IDLE_CYC = `FPP_IDLE_CYC
) (
	input  wire logic               ref_clk,
	input  wire logic               arst_n,
	input  wire logic               ce,
	input  wire logic               core_halted,
	input  wire logic               debug_clock_pin,
	input  wire logic               debug_data_pin_i,
	output logic                    debug_data_pin_o,
	output logic                    debug_data_pin_oe,
	output logic                    pin_borrow,
	output logic                    periph_stall,
	output logic                    prog_mode,
	output logic                    flash_cmd_stb,
	output logic [7:0]              flash_cmd,
	output logic                    flash_byte_stb,
	output logic [7:0]              flash_byte,
	input  wire logic               flash_done,
	input  wire logic               flash_rd_stb,
	input  wire logic [7:0]         flash_rd_byte
);
	import fpp_pkg::*;

	// Valid command codes; used by the gate and by its check
	function automatic logic is_cmd(input logic [7:0] b);
		is_cmd = (b == `FPP_CMD_BLK_RD) || (b == `FPP_CMD_BLK_WR) ||
			(b == `FPP_CMD_PG_ERASE) || (b == `FPP_CMD_DEV_ERASE);
	endfunction

	logic [2:0]  ck_sync_ff;
	logic [2:0]  d_sync_ff;
	logic        ck_lvl_ff;
	logic        d_lvl_ff;
	logic [15:0] idle_cnt_ff;
	logic [3:0]  bit_ff;
	logic [1:0]  instr_ff;
	logic [7:0]  in_sh_ff;
	logic [7:0]  out_sh_ff;
	logic        drive_ff;
	logic [7:0]  addr_ff;
	logic [7:0]  ctl_ff;
	logic [7:0]  dat_ff;
	fpp_lock_t   lock_ff;
	fpp_lock_t   nxt_lock;
	logic        cmd_open_ff;
	logic        cmd_stb_ff;
	logic [7:0]  cmd_ff;
	logic        byte_stb_ff;
	logic [7:0]  byte_ff;

	// Pin synchronisers; only the agreeing second and third stages are looked at
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ck_sync_ff <= 3'h7;
			d_sync_ff  <= 3'h7;
		end else if (ce) begin
			ck_sync_ff <= {ck_sync_ff[1:0], debug_clock_pin};
			d_sync_ff  <= {d_sync_ff[1:0], debug_data_pin_i};
		end
	end

	wire ck_agree = (ck_sync_ff[1] == ck_sync_ff[2]);
	wire d_agree  = (d_sync_ff[1] == d_sync_ff[2]);
	wire ck_rise  = ck_agree && ck_sync_ff[2] && !ck_lvl_ff;
	wire link_rise = ck_rise && core_halted;
	wire [7:0] rx_byte = {d_lvl_ff, in_sh_ff[7:1]};
	wire last_bit  = link_rise && (bit_ff == `FPP_LAST_BIT);
	wire instr_done = link_rise && (bit_ff == `FPP_INSTR_BITS - 4'd1);
	wire fpp_instr_t cur_instr = fpp_instr_t'({d_lvl_ff, instr_ff[1]}); // Bit 0 sits in [1]
	wire idle_end = (idle_cnt_ff == 16'(IDLE_CYC - 1));

	// Filtered levels follow the pins once two stages agree
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ck_lvl_ff <= 1'b1;
			d_lvl_ff  <= 1'b1;
		end else if (ce) begin
			if (ck_agree)
				ck_lvl_ff <= ck_sync_ff[2];
			if (d_agree)
				d_lvl_ff <= d_sync_ff[2];
		end
	end

	// Clock held high long enough realigns the frame; guards against a lost bit
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			idle_cnt_ff <= 16'h0000;
		end else if (ce) begin
			if (!ck_lvl_ff || idle_end)
				idle_cnt_ff <= 16'h0000;
			else
				idle_cnt_ff <= idle_cnt_ff + 16'h0001;
		end
	end

	// Bit position within the frame and shift-in of host bits
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			bit_ff   <= 4'h0;
			instr_ff <= 2'h0;
			in_sh_ff <= 8'h00;
		end else if (ce) begin
			if (idle_end || !core_halted || last_bit)
				bit_ff <= 4'h0;
			else if (link_rise)
				bit_ff <= bit_ff + 4'h1;
			if (link_rise && bit_ff < `FPP_INSTR_BITS)
				instr_ff <= {d_lvl_ff, instr_ff[1]};
			else if (link_rise)
				in_sh_ff <= rx_byte;
		end
	end

	wire [7:0] sel_val = (addr_ff == `FPP_ADDR_CTL) ? ctl_ff :
		(addr_ff == `FPP_ADDR_DAT) ? dat_ff : 8'h00;
	wire rd_start = instr_done &&
		(cur_instr == FPP_I_DATA_RD || cur_instr == FPP_I_ADDR_RD);
	wire [7:0] rd_val = (cur_instr == FPP_I_ADDR_RD) ? addr_ff : sel_val;
	wire fpp_instr_t frm_instr = fpp_instr_t'(instr_ff);
	wire wr_addr = last_bit && frm_instr == FPP_I_ADDR_WR;
	wire wr_data = last_bit && frm_instr == FPP_I_DATA_WR;
	wire wr_ctl  = wr_data && addr_ff == `FPP_ADDR_CTL;
	wire wr_dat  = wr_data && addr_ff == `FPP_ADDR_DAT;

	// Read phase: device drives one bit per debug clock, LSB first
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			out_sh_ff <= 8'h00;
			drive_ff  <= 1'b0;
		end else if (ce) begin
			if (rd_start) begin
				out_sh_ff <= rd_val;
				drive_ff  <= 1'b1;
			end else if (last_bit || idle_end || !core_halted) begin
				drive_ff <= 1'b0;
			end else if (link_rise && drive_ff) begin
				out_sh_ff <= {1'b0, out_sh_ff[7:1]};
			end
		end
	end

	assign debug_data_pin_oe = drive_ff && core_halted;
	assign debug_data_pin_o  = out_sh_ff[0];
	assign pin_borrow        = core_halted;
	assign periph_stall      = core_halted;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			addr_ff <= `FPP_ADDR_RST;
			ctl_ff  <= `FPP_CTL_RST;
			dat_ff  <= `FPP_DAT_RST;
		end else if (ce) begin
			if (wr_addr)
				addr_ff <= rx_byte;
			if (wr_ctl)
				ctl_ff <= rx_byte;
			// Host write wins over flash read-back in the same cycle
			if (wr_dat)
				dat_ff <= rx_byte;
			else if (flash_rd_stb)
				dat_ff <= flash_rd_byte;
		end
	end

	always_comb begin
		nxt_lock = lock_ff;
		if (wr_ctl && lock_ff != FPP_OPEN) begin
			if (lock_ff == FPP_HALF && rx_byte == `FPP_UNLOCK_SECOND)
				nxt_lock = FPP_OPEN;
			else if (rx_byte == `FPP_UNLOCK_FIRST)
				nxt_lock = FPP_HALF;
			else
				nxt_lock = FPP_LOCKED;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			lock_ff <= FPP_LOCKED;
		else if (ce)
			lock_ff <= nxt_lock;
	end
	assign prog_mode = (lock_ff == FPP_OPEN);

	wire is_first = wr_dat && prog_mode && !cmd_open_ff;
	wire cmd_ok   = is_first && is_cmd(rx_byte);
	wire operand  = wr_dat && prog_mode && cmd_open_ff;

	// Command and operand strobes; done closes a command, a new one wins
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cmd_open_ff <= 1'b0;
			cmd_stb_ff  <= 1'b0;
			cmd_ff      <= 8'h00;
			byte_stb_ff <= 1'b0;
			byte_ff     <= 8'h00;
		end else if (ce) begin
			cmd_stb_ff  <= cmd_ok;
			byte_stb_ff <= operand;
			if (cmd_ok)
				cmd_ff <= rx_byte;
			if (operand)
				byte_ff <= rx_byte;
			if (cmd_ok)
				cmd_open_ff <= 1'b1;
			else if (flash_done)
				cmd_open_ff <= 1'b0;
		end
	end
	assign flash_cmd_stb  = cmd_stb_ff;
	assign flash_cmd      = cmd_ff;
	assign flash_byte_stb = byte_stb_ff;
	assign flash_byte     = byte_ff;

	a_unlock_second: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(ce && wr_ctl && lock_ff == FPP_HALF && rx_byte == `FPP_UNLOCK_SECOND)
		|=> lock_ff == FPP_OPEN)
		else $error("second unlock code did not open programming");
	a_unlock_first: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(ce && wr_ctl && lock_ff == FPP_LOCKED) |=> lock_ff != FPP_OPEN)
		else $error("programming opened without first code");
	a_mode_sticky: assert property (@(posedge ref_clk) disable iff (!arst_n)
		prog_mode |=> prog_mode)
		else $error("programming mode left without reset");
	a_cmd_gated: assert property (@(posedge ref_clk) disable iff (!arst_n)
		$rose(flash_cmd_stb) |-> $past(prog_mode, 1))
		else $error("command issued while locked");
	a_cmd_code: assert property (@(posedge ref_clk) disable iff (!arst_n)
		flash_cmd_stb |-> is_cmd(flash_cmd) && flash_cmd == $past(rx_byte))
		else $error("bad flash command code");
	a_ctl_write: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(ce && wr_ctl) |=> ctl_ff == $past(rx_byte))
		else $error("control register not written");
	a_dat_write: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(ce && wr_dat) |=> dat_ff == $past(rx_byte))
		else $error("data register not written");
	a_pin_release: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(ce && !core_halted) |-> !debug_data_pin_oe ##1 (!drive_ff || core_halted))
		else $error("data pin driven outside halt");
	a_addr_select: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(ce && rd_start && cur_instr == FPP_I_DATA_RD && addr_ff == `FPP_ADDR_CTL)
		|=> out_sh_ff == $past(ctl_ff))
		else $error("read did not follow selected address");
	a_page_erase: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(ce && cmd_ok && rx_byte == `FPP_CMD_PG_ERASE) |=> flash_cmd == `FPP_CMD_PG_ERASE)
		else $error("erase command lost");
endmodule
`default_nettype wire

// ### verification/fpp_host.sv
// Host programmer model driving the two-wire debug link
`timescale 1ns/1ps
`default_nettype none
module fpp_host (
	input  wire logic ref_clk,
	input  wire logic link_d,
	output logic      link_clk,
	output logic      host_d
);
	// Link clock idles high and stands still between frames
	initial begin
		link_clk = 1'b1;
		host_d   = 1'b0;
	end
	// reset pin is never driven from here
	// data drive moves only inside frames
	task automatic frame(input logic [1:0] ins, input logic [7:0] wd, output logic [7:0] rd);
		logic [9:0] bits;
		bits = {wd, ins};
		rd   = 8'h00;
		for (int i = 0; i < 10; i++) begin
			@(posedge ref_clk);
			link_clk <= 1'b0;
			// Released line toggles so a stale level never reads as data
			host_d   <= (ins[1] && i > 1) ? ~host_d : bits[i];
			repeat (4) @(posedge ref_clk);
			if (i > 1) rd[i-2] = link_d;
			link_clk <= 1'b1;
			repeat (3) @(posedge ref_clk);
		end
	endtask
endmodule
`default_nettype wire

// ### verification/tb.sv
// Self-checking bench for the flash programming port
`timescale 1ns/1ps
`default_nettype none
`include "fpp_map.svh"
module tb;
	import fpp_pkg::*;
	logic       ref_clk, arst_n, halted, done, rd_stb, link_clk, host_d, ce;
	logic       d_o, d_oe, borrow, stall, prog_mode, cmd_stb, byte_stb;
	logic [7:0] rd_byte, flash_cmd, flash_byte, v;
	int         n_fail, check_count, n_cmd, n_byte, cycles, k;
	logic [7:0] codes [4];
	wire        link_d = d_oe ? d_o : host_d;

	fpp_port i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .ce(ce), .core_halted(halted),
		.debug_clock_pin(link_clk), .debug_data_pin_i(link_d), .debug_data_pin_o(d_o),
		.debug_data_pin_oe(d_oe), .pin_borrow(borrow), .periph_stall(stall),
		.prog_mode(prog_mode), .flash_cmd_stb(cmd_stb), .flash_cmd(flash_cmd),
		.flash_byte_stb(byte_stb), .flash_byte(flash_byte), .flash_done(done),
		.flash_rd_stb(rd_stb), .flash_rd_byte(rd_byte));
	fpp_host i_host (.ref_clk(ref_clk), .link_d(link_d), .link_clk(link_clk), .host_d(host_d));

	// Clock
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	// Strobe counters and hang guard
	always @(posedge ref_clk) begin
		cycles++;
		if (cmd_stb === 1'b1) n_cmd++;
		if (byte_stb === 1'b1) n_byte++;
		if (cycles == 20000) begin
			n_fail++;
			stop_test();
		end
	end
	task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Register access: select by address, then data frame
	task wr(input logic [7:0] a, input logic [7:0] d);
		i_host.frame(FPP_I_ADDR_WR, a, v);
		i_host.frame(FPP_I_DATA_WR, d, v);
		repeat (8) @(posedge ref_clk);
	endtask
	task rdr(input logic [7:0] a);
		i_host.frame(FPP_I_ADDR_WR, a, v);
		i_host.frame(FPP_I_DATA_RD, 8'h00, v);
		repeat (8) @(posedge ref_clk);
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Main sequence
	initial begin
		codes = '{`FPP_CMD_BLK_RD, `FPP_CMD_BLK_WR, `FPP_CMD_PG_ERASE, `FPP_CMD_DEV_ERASE};
		arst_n = 1'b0; halted = 1'b1; done = 1'b0; rd_stb = 1'b0; rd_byte = 8'h00;
		ce = 1'b1;
		repeat (8) @(posedge ref_clk);
		arst_n <= 1'b1;
		repeat (6) @(posedge ref_clk);
		check("borrow", {7'h00, borrow}, 8'h01);
		check("stall", {7'h00, stall}, 8'h01);
		rdr(`FPP_ADDR_CTL);
		check("ctl reset", v, `FPP_CTL_RST);
		rdr(`FPP_ADDR_DAT);
		check("dat reset", v, `FPP_DAT_RST);
		$display("test reset done");
		wr(`FPP_ADDR_DAT, `FPP_CMD_BLK_WR);
		check("locked cmd", 8'(n_cmd), 8'h00);
		wr(`FPP_ADDR_CTL, `FPP_UNLOCK_SECOND);
		wr(`FPP_ADDR_CTL, `FPP_UNLOCK_FIRST);
		check("half open", {7'h00, prog_mode}, 8'h00);
		wr(`FPP_ADDR_CTL, `FPP_UNLOCK_SECOND);
		check("open", {7'h00, prog_mode}, 8'h01);
		rdr(`FPP_ADDR_CTL);
		check("ctl read", v, `FPP_UNLOCK_SECOND);
		i_host.frame(FPP_I_ADDR_RD, 8'h00, v);
		check("addr read", v, `FPP_ADDR_CTL);
		$display("test unlock done");
		for (k = 0; k < 4; k++) begin
			wr(`FPP_ADDR_DAT, codes[k]);
			check("cmd count", 8'(n_cmd), 8'(k + 1));
			check("cmd code", flash_cmd, codes[k]);
			wr(`FPP_ADDR_DAT, 8'h5a + 8'(k));
			check("byte count", 8'(n_byte), 8'(k + 1));
			check("byte", flash_byte, 8'h5a + 8'(k));
			@(posedge ref_clk) done <= 1'b1;
			@(posedge ref_clk) done <= 1'b0;
		end
		$display("test commands done");
		@(posedge ref_clk) begin
			rd_stb  <= 1'b1;
			rd_byte <= 8'hc3;
		end
		@(posedge ref_clk) rd_stb <= 1'b0;
		rdr(`FPP_ADDR_DAT);
		check("dat load", v, 8'hc3);
		// Frozen block must miss a whole write frame
		@(posedge ref_clk) ce <= 1'b0;
		wr(`FPP_ADDR_DAT, 8'h77);
		@(posedge ref_clk) ce <= 1'b1;
		rdr(`FPP_ADDR_DAT);
		check("ce freeze", v, 8'hc3);
		// Unknown first byte is stored but starts nothing
		wr(`FPP_ADDR_DAT, 8'h77);
		check("no cmd", 8'(n_cmd), 8'h04);
		rdr(`FPP_ADDR_DAT);
		check("dat store", v, 8'h77);
		$display("test readback done");
		@(posedge ref_clk) halted <= 1'b0;
		repeat (4) @(posedge ref_clk);
		check("release", {6'h00, borrow, stall}, 8'h00);
		check("oe off", {7'h00, d_oe}, 8'h00);
		check("stays open", {7'h00, prog_mode}, 8'h01);
		@(posedge ref_clk) arst_n <= 1'b0;
		@(posedge ref_clk) arst_n <= 1'b1;
		@(posedge ref_clk);
		check("reset leaves", {7'h00, prog_mode}, 8'h00);
		$display("test run mode done");
		stop_test();
	end
endmodule
`default_nettype wire
